/* hw/cds_pkg.sv */
// cursor and display status package: offsets, masks, bit positions
// assumes: 20-bit memory offsets, 32-bit register data
package cds_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [19:0] CDS_OFF_STAT     = 20'h70024;
    localparam logic [19:0] CDS_OFF_CUR_CTL  = 20'h70080;
    localparam logic [19:0] CDS_OFF_CUR_BASE = 20'h70084;
    localparam logic [19:0] CDS_OFF_CUR_POS  = 20'h70088;

    // ****************************************
    // field layouts and reset values
    // ****************************************
    localparam logic [31:0] CDS_CUR_CTL_MASK  = 32'h0000_0017;
    localparam logic [31:0] CDS_CUR_BASE_MASK = 32'h1fff_ff00;
    localparam logic [31:0] CDS_CUR_POS_MASK  = 32'h87ff_87ff;
    localparam logic [31:0] CDS_CUR_RST       = 32'h0000_0000;
    localparam logic [3:0]  CDS_BE_FULL       = 4'hf;

    localparam int CDS_B_OVL    = 0;
    localparam int CDS_B_VBL    = 1;
    localparam int CDS_B_LCMP   = 8;
    localparam int CDS_B_VSYNC  = 9;
    localparam int CDS_B_HPEDGE = 10;
    localparam int CDS_B_HPLVL  = 15;
    localparam int CDS_B_ORIGIN = 4;
    localparam int CDS_MODE_MSB = 2;
    localparam int CDS_BASE_LSB = 8;

    localparam logic [15:0] CDS_STAT_MASK = 16'h0703;
    localparam logic [15:0] CDS_EN_MASK   = 16'h0703;
    localparam logic [15:0] CDS_GRP_VBL   = 16'h0003;
    localparam logic [15:0] CDS_GRP_DISP  = 16'h0700;
    localparam logic [15:0] CDS_STAT_RST  = 16'h8000;
    localparam logic [15:0] CDS_EN_RST    = 16'h0000;
    localparam logic [2:0]  CDS_PAL_CUR_BASE = 3'h4;

    // ****************************************
    // cursor modes
    // ****************************************
    typedef enum logic [2:0] {
        CDS_CUR_OFF   = 3'h0,
        CDS_CUR_32_AX = 3'h1,
        CDS_CUR_64_3C = 3'h4,
        CDS_CUR_64_AX = 3'h5,
        CDS_CUR_64_4C = 3'h6
    } cds_cur_mode_t;

endpackage : cds_pkg

/* hw/cds_dbuf_if.sv */
// staging/active register carrier between top and double-buffered regs
// assumes: single clock domain
`timescale 1ns/10ps
interface cds_dbuf_if #(parameter int W = 32);
    logic         wr;
    logic [W-1:0] wdata;
    logic         load;
    logic [W-1:0] active;
    modport ctl  (output wr, output wdata, output load, input active);
    modport regs (input wr, input wdata, input load, output active);
endinterface : cds_dbuf_if

/* hw/cds_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes: input asynchronous to i_clk
`timescale 1ns/10ps
module cds_pin_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_d,
    output logic      o_q
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } cds_sync_st_t;

    cds_sync_st_t st_r;
    cds_sync_st_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = i_d;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.q = st_r.s3;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_q = st_r.q;
endmodule : cds_pin_sync

/* hw/cds_dbuf_reg.sv */
// double-buffered register: staging copy, active copy loaded on strobe
// assumes: write and load strobes are single-cycle, same clock
`timescale 1ns/10ps
module cds_dbuf_reg #(
    parameter int           W    = 32,
    parameter logic [W-1:0] MASK = '1,
    parameter logic [W-1:0] RST  = '0
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    cds_dbuf_if.regs  bus
);
    typedef struct packed {
        logic [W-1:0] stage;
        logic [W-1:0] active;
    } cds_dbuf_st_t;

    cds_dbuf_st_t st_r;
    cds_dbuf_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (bus.wr) begin
            st_nxt.stage = bus.wdata & MASK;
        end
        if (bus.load) begin
            st_nxt.active = st_r.stage;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '{stage: RST, active: RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.active = st_r.active;
endmodule : cds_dbuf_reg

/* hw/cds_top.sv */
// display event status select register and hardware cursor registers
// assumes: display timing inputs on i_clk, hot-plug pin asynchronous
//
// Functional notes
// - bit 16 enables overlay-updated event relative to vertical blank.
// - bit 15 mirrors active-low hot-plug pin level; reads 1 while pin serves as PLL reference clock.
// - bit 10 latches on 1-to-0 of bit 15, holds until cleared.
// - edge catcher held zero while pin serves as PLL reference clock.
// - bit 9 shows captured vertical sync event.
// - bit 8 shows captured line-compare event.
// - bit 1 shows captured vertical blank event.
// - bit 0 records whether overlay update happened inside vertical blank.
// - cursor registers accept only full 32-bit writes.
// - cursor colours use extended palette entries 4 to 7.
// - cursor registers staged, made active at vertical sync rising edge.
// - control bit 4 picks border corner or active-area origin.
// - mode 000 off, 001 32x32 mode, 100/101/110 64x64 modes, others reserved.
// - base field gives bits 28:8 of 29-bit address, low bits zero.
// - cursor image fetched from system memory only.
// - vertical position sign bit 31, magnitude 26:16, reset zero.
// - horizontal position sign bit 15, magnitude 10:0, reset zero.
// - status captures only when enabled; writing 1 clears it.
// - bits 0,1 form vblank event; bits 8,9,10 form display event.
// - enables in upper half; writes honour byte enables.
`timescale 1ns/10ps
module cds_top
    import cds_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [19:0] i_addr,
    input  wire logic [3:0]  i_be,
    input  wire logic [31:0] i_wdata,
    output logic      [31:0] o_rdata,
    output logic             o_rvalid,
    input  wire logic        i_vsync,
    input  wire logic        i_vblank,
    input  wire logic        i_line_cmp,
    input  wire logic        i_ovl_upd,
    input  wire logic        i_hotplug_or_refclk_pin_n,
    input  wire logic        i_hp_pin_is_refclk,
    input  wire logic [1:0]  i_cur_pix,
    output logic             o_vblank_evt,
    output logic             o_disp_evt,
    output logic      [2:0]  o_cur_mode,
    output logic             o_cur_enable,
    output logic             o_cur_origin_active,
    output logic      [28:0] o_cur_base_addr,
    output logic             o_cur_sysmem_only,
    output logic             o_cur_y_sign,
    output logic      [10:0] o_cur_y_mag,
    output logic             o_cur_x_sign,
    output logic      [10:0] o_cur_x_mag,
    output logic      [2:0]  o_cur_pal_idx
);

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ****************************************
    // hot-plug pin and cursor registers
    // ****************************************
    logic hp_sync;

    cds_pin_sync #(.RST_VAL(1'b1)) u_hp_sync (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_d     (i_hotplug_or_refclk_pin_n),
        .o_q     (hp_sync)
    );

    cds_dbuf_if #(.W(32)) ctl_if ();
    cds_dbuf_if #(.W(32)) base_if ();
    cds_dbuf_if #(.W(32)) pos_if ();

    cds_dbuf_reg #(.W(32), .MASK(CDS_CUR_CTL_MASK), .RST(CDS_CUR_RST))
        u_ctl (.i_clk(i_clk), .i_rst_n(rst_n), .bus(ctl_if.regs));
    cds_dbuf_reg #(.W(32), .MASK(CDS_CUR_BASE_MASK), .RST(CDS_CUR_RST))
        u_base (.i_clk(i_clk), .i_rst_n(rst_n), .bus(base_if.regs));
    cds_dbuf_reg #(.W(32), .MASK(CDS_CUR_POS_MASK), .RST(CDS_CUR_RST))
        u_pos (.i_clk(i_clk), .i_rst_n(rst_n), .bus(pos_if.regs));

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic        vsync_d;
        logic        vblank_d;
        logic        hp_lvl_d;
        logic [15:0] st;
        logic [15:0] en;
        logic [31:0] rdata;
        logic        rvalid;
        logic        vbl_evt;
        logic        disp_evt;
        logic        cur_en;
        logic [2:0]  pal_idx;
        logic        sysmem;
    } cds_top_st_t;

    cds_top_st_t s_r;
    cds_top_st_t s_nxt;

    logic        vs_edge;
    logic        vbl_edge;
    logic        hp_lvl;
    logic        stat_wr;
    logic        cur_wr;
    logic [15:0] clr;
    logic [15:0] ev;

    assign vs_edge  = i_vsync & ~s_r.vsync_d;
    assign vbl_edge = i_vblank & ~s_r.vblank_d;
    assign hp_lvl   = i_hp_pin_is_refclk | hp_sync;
    assign stat_wr  = i_wr & (i_addr == CDS_OFF_STAT);
    assign cur_wr   = i_wr & (i_be == CDS_BE_FULL);

    assign ctl_if.wr     = cur_wr & (i_addr == CDS_OFF_CUR_CTL);
    assign base_if.wr    = cur_wr & (i_addr == CDS_OFF_CUR_BASE);
    assign pos_if.wr     = cur_wr & (i_addr == CDS_OFF_CUR_POS);
    assign ctl_if.wdata  = i_wdata;
    assign base_if.wdata = i_wdata;
    assign pos_if.wdata  = i_wdata;
    assign ctl_if.load   = vs_edge;
    assign base_if.load  = vs_edge;
    assign pos_if.load   = vs_edge;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_nxt        = s_r;
        s_nxt.rvalid = 1'b0;
        s_nxt.vsync_d  = i_vsync;
        s_nxt.vblank_d = i_vblank;
        s_nxt.hp_lvl_d = hp_lvl;
        clr = 16'h0000;
        if (stat_wr) begin
            clr = {{8{i_be[1]}}, {8{i_be[0]}}} & i_wdata[15:0]
                  & CDS_STAT_MASK;
            if (i_be[2]) begin
                s_nxt.en[7:0] = i_wdata[23:16] & CDS_EN_MASK[7:0];
            end
            if (i_be[3]) begin
                s_nxt.en[15:8] = i_wdata[31:24] & CDS_EN_MASK[15:8];
            end
        end
        ev = 16'h0000;
        ev[CDS_B_VBL]   = vbl_edge & s_r.en[CDS_B_VBL];
        ev[CDS_B_LCMP]  = i_line_cmp & s_r.en[CDS_B_LCMP];
        ev[CDS_B_VSYNC] = vs_edge & s_r.en[CDS_B_VSYNC];
        ev[CDS_B_HPEDGE] = s_r.hp_lvl_d & ~hp_lvl & ~i_hp_pin_is_refclk
                           & s_r.en[CDS_B_HPEDGE];
        // set wins over a clear in the same cycle
        s_nxt.st = (s_r.st & ~clr) | ev;
        if (i_ovl_upd & s_r.en[CDS_B_OVL]) begin
            s_nxt.st[CDS_B_OVL] = i_vblank;
        end
        if (i_hp_pin_is_refclk) begin
            s_nxt.st[CDS_B_HPEDGE] = 1'b0;
        end
        s_nxt.st[CDS_B_HPLVL] = hp_lvl;
        s_nxt.vbl_evt  = |(s_r.st & s_r.en & CDS_GRP_VBL);
        s_nxt.disp_evt = |(s_r.st & s_r.en & CDS_GRP_DISP);
        unique case (ctl_if.active[CDS_MODE_MSB:0])
            CDS_CUR_32_AX: s_nxt.cur_en = 1'b1;
            CDS_CUR_64_3C, CDS_CUR_64_AX,
            CDS_CUR_64_4C: s_nxt.cur_en = 1'b1;
            default:       s_nxt.cur_en = 1'b0;
        endcase
        s_nxt.pal_idx = CDS_PAL_CUR_BASE | {1'b0, i_cur_pix};
        s_nxt.sysmem  = 1'b1;
        if (i_rd) begin
            s_nxt.rvalid = 1'b1;
            unique case (i_addr)
                CDS_OFF_STAT:     s_nxt.rdata = {s_r.en, s_r.st};
                CDS_OFF_CUR_CTL:  s_nxt.rdata = ctl_if.active;
                CDS_OFF_CUR_BASE: s_nxt.rdata = base_if.active;
                CDS_OFF_CUR_POS:  s_nxt.rdata = pos_if.active;
                default:          s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{vsync_d: 1'b0, vblank_d: 1'b0, hp_lvl_d: 1'b1,
                     st: CDS_STAT_RST, en: CDS_EN_RST, rdata: 32'h0,
                     rvalid: 1'b0, vbl_evt: 1'b0, disp_evt: 1'b0,
                     cur_en: 1'b0, pal_idx: CDS_PAL_CUR_BASE, sysmem: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_rdata      = s_r.rdata;
    assign o_rvalid     = s_r.rvalid;
    assign o_vblank_evt = s_r.vbl_evt;
    assign o_disp_evt   = s_r.disp_evt;
    assign o_cur_mode   = ctl_if.active[CDS_MODE_MSB:0];
    assign o_cur_enable = s_r.cur_en;
    assign o_cur_origin_active = ctl_if.active[CDS_B_ORIGIN];
    assign o_cur_base_addr = {base_if.active[28:CDS_BASE_LSB],
                              8'h00};
    assign o_cur_sysmem_only = s_r.sysmem;
    assign o_cur_y_sign = pos_if.active[31];
    assign o_cur_y_mag  = pos_if.active[26:16];
    assign o_cur_x_sign = pos_if.active[15];
    assign o_cur_x_mag  = pos_if.active[10:0];
    assign o_cur_pal_idx = s_r.pal_idx;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    chk_hp_level_low: assert property (
        (!i_hp_pin_is_refclk && !hp_sync) |=> !s_r.st[CDS_B_HPLVL])
        else $error("hot-plug level bit not low while pin asserted");
    chk_hp_edge_set: assert property (
        ($fell(hp_lvl) && s_r.en[CDS_B_HPEDGE] && !i_hp_pin_is_refclk)
        |=> s_r.st[CDS_B_HPEDGE])
        else $error("hot-plug edge not caught");
    chk_hp_refclk_zero: assert property (
        i_hp_pin_is_refclk |=> !s_r.st[CDS_B_HPEDGE])
        else $error("edge catcher set while pin is reference clock");
    chk_vsync_capture: assert property (
        (vs_edge && s_r.en[CDS_B_VSYNC]) |=> s_r.st[CDS_B_VSYNC])
        else $error("vsync event not captured");
    chk_lcmp_capture: assert property (
        (i_line_cmp && s_r.en[CDS_B_LCMP]) |=> s_r.st[CDS_B_LCMP])
        else $error("line compare event not captured");
    chk_vblank_capture: assert property (
        (vbl_edge && s_r.en[CDS_B_VBL]) |=> s_r.st[CDS_B_VBL])
        else $error("vblank event not captured");
    chk_ovl_record: assert property (
        (i_ovl_upd && s_r.en[CDS_B_OVL])
        |=> s_r.st[CDS_B_OVL] == $past(i_vblank))
        else $error("overlay update not recorded against vblank");
    chk_active_hold: assert property (
        !vs_edge |=> $stable(ctl_if.active) && $stable(base_if.active)
                     && $stable(pos_if.active))
        else $error("cursor active copy changed without vsync");
    chk_w1c_clear: assert property (
        (clr[CDS_B_VSYNC] && !ev[CDS_B_VSYNC]) |=> !s_r.st[CDS_B_VSYNC])
        else $error("write one did not clear vsync status");
    chk_vbl_output: assert property (
        (s_r.st[CDS_B_VBL] && s_r.en[CDS_B_VBL]) |=> o_vblank_evt)
        else $error("vblank event output missing");
    chk_disp_output: assert property (
        (|(s_r.st & s_r.en & CDS_GRP_DISP)) |=> o_disp_evt)
        else $error("display event output missing");
    chk_mode_legal: assert property (
        (ctl_if.active[2:0] == 3'h7) |=> !o_cur_enable)
        else $error("reserved cursor mode enabled");
    chk_pal_range: assert property (
        (i_cur_pix == 2'h3) |=> o_cur_pal_idx == 3'h7)
        else $error("cursor palette index out of range");
    chk_read_answer: assert property (
        i_rd |=> o_rvalid)
        else $error("read strobe without answer");
    chk_hp_refclk_level: assert property (
        i_hp_pin_is_refclk |=> s_r.st[CDS_B_HPLVL])
        else $error("hot-plug level bit low while pin is reference clock");
    chk_hp_level_high: assert property (
        (!i_hp_pin_is_refclk && hp_sync) |=> s_r.st[CDS_B_HPLVL])
        else $error("hot-plug level bit low while pin released");
    chk_enable_write: assert property (
        (stat_wr && i_be[3])
        |=> s_r.en[15:8] == ($past(i_wdata[31:24]) & CDS_EN_MASK[15:8]))
        else $error("upper enable byte not written");
    chk_disabled_drop: assert property (
        (!s_r.en[CDS_B_LCMP] && !s_r.st[CDS_B_LCMP])
        |=> !s_r.st[CDS_B_LCMP])
        else $error("disabled line compare event captured");

    cov_vsync_load: cover property (ctl_if.wr ##[1:20] vs_edge);
    cov_hp_edge: cover property ($fell(hp_lvl) && s_r.en[CDS_B_HPEDGE]);
    cov_set_clear: cover property (clr[CDS_B_VSYNC] && ev[CDS_B_VSYNC]);
    cov_ovl_vblank: cover property (i_ovl_upd && i_vblank);
    cov_mode_32x32: cover property (ctl_if.active[2:0] == 3'h1);

endmodule : cds_top

/* tb/test_cursor_and_display_status.sv */
// bench for cds_top: registers, double buffering, events, hot-plug pin
// assumes: cds_pkg, cds_dbuf_if and the hw modules are compiled first
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin \
    miscompares++; $display("FAIL %0t %s got %h exp %h", $time, msg, \
    (got), (exp)); end end
module test_cursor_and_display_status
    import cds_pkg::*;
;
    // ****************************************
    // stimulus signals and design instance
    // ****************************************
    logic        i_clk;
    logic        i_rst_n;
    logic        i_wr;
    logic        i_rd;
    logic [19:0] i_addr;
    logic [3:0]  i_be;
    logic [31:0] i_wdata;
    logic [31:0] o_rdata;
    logic        o_rvalid;
    logic        i_vsync;
    logic        i_vblank;
    logic        i_line_cmp;
    logic        i_ovl_upd;
    logic        i_hp_pin_n;
    logic        i_hp_refclk;
    logic [1:0]  i_cur_pix;
    logic        o_vblank_evt;
    logic        o_disp_evt;
    logic [2:0]  o_cur_mode;
    logic        o_cur_enable;
    logic        o_cur_origin_active;
    logic [28:0] o_cur_base_addr;
    logic        o_cur_sysmem_only;
    logic        o_cur_y_sign;
    logic [10:0] o_cur_y_mag;
    logic        o_cur_x_sign;
    logic [10:0] o_cur_x_mag;
    logic [2:0]  o_cur_pal_idx;
    int          miscompares;
    int          n_checks;

    cds_top u_dut (
        .i_clk                     (i_clk),
        .i_rst_n                   (i_rst_n),
        .i_wr                      (i_wr),
        .i_rd                      (i_rd),
        .i_addr                    (i_addr),
        .i_be                      (i_be),
        .i_wdata                   (i_wdata),
        .o_rdata                   (o_rdata),
        .o_rvalid                  (o_rvalid),
        .i_vsync                   (i_vsync),
        .i_vblank                  (i_vblank),
        .i_line_cmp                (i_line_cmp),
        .i_ovl_upd                 (i_ovl_upd),
        .i_hotplug_or_refclk_pin_n (i_hp_pin_n),
        .i_hp_pin_is_refclk        (i_hp_refclk),
        .i_cur_pix                 (i_cur_pix),
        .o_vblank_evt              (o_vblank_evt),
        .o_disp_evt                (o_disp_evt),
        .o_cur_mode                (o_cur_mode),
        .o_cur_enable              (o_cur_enable),
        .o_cur_origin_active       (o_cur_origin_active),
        .o_cur_base_addr           (o_cur_base_addr),
        .o_cur_sysmem_only         (o_cur_sysmem_only),
        .o_cur_y_sign              (o_cur_y_sign),
        .o_cur_y_mag               (o_cur_y_mag),
        .o_cur_x_sign              (o_cur_x_sign),
        .o_cur_x_mag               (o_cur_x_mag),
        .o_cur_pal_idx             (o_cur_pal_idx)
    );

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // ****************************************
    // bus and strobe tasks
    // ****************************************
    task automatic wr(input logic [19:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_be    <= be;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [19:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rvalid, 1'b1, "read answer")
        `CHK(o_rdata, e, "read data")
    endtask : rd_chk

    task automatic vs_pulse;
        @(posedge i_clk);
        i_vsync <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_vsync <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
    endtask : vs_pulse

    task automatic strobe(input logic lc, input logic ov);
        @(posedge i_clk);
        i_line_cmp <= lc;
        i_ovl_upd  <= ov;
        @(posedge i_clk);
        i_line_cmp <= 1'b0;
        i_ovl_upd  <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
    endtask : strobe

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rd_chk(CDS_OFF_CUR_CTL, 32'h0);
        rd_chk(CDS_OFF_CUR_BASE, 32'h0);
        rd_chk(CDS_OFF_CUR_POS, 32'h0);
        rd_chk(CDS_OFF_STAT, 32'h0000_8000);
        rd_chk(20'h70040, 32'h0);
        `CHK(o_cur_sysmem_only, 1'b1, "system memory only")
    endtask : t_reset

    task automatic t_dbuf;
        wr(CDS_OFF_CUR_CTL, 4'hf, 32'h0000_0014);
        rd_chk(CDS_OFF_CUR_CTL, 32'h0);
        `CHK(o_cur_mode, 3'h0, "mode before vsync")
        vs_pulse();
        rd_chk(CDS_OFF_CUR_CTL, 32'h0000_0014);
        `CHK(o_cur_origin_active, 1'b1, "origin")
    endtask : t_dbuf

    task automatic t_modes;
        logic en;
        for (int m = 0; m < 8; m++) begin
            wr(CDS_OFF_CUR_CTL, 4'hf, 32'(m));
            vs_pulse();
            en = (m == 1 || m == 4 || m == 5 || m == 6);
            `CHK(o_cur_mode, 3'(m), "mode")
            `CHK(o_cur_enable, en, "mode enable")
        end
    endtask : t_modes

    task automatic t_base_pos;
        wr(CDS_OFF_CUR_BASE, 4'hf, 32'hffff_ffff);
        wr(CDS_OFF_CUR_BASE, 4'h7, 32'h0);
        wr(CDS_OFF_CUR_POS, 4'hf, 32'hffff_ffff);
        vs_pulse();
        rd_chk(CDS_OFF_CUR_BASE, 32'h1fff_ff00);
        `CHK(o_cur_base_addr, 29'h1fff_ff00, "base")
        rd_chk(CDS_OFF_CUR_POS, 32'h87ff_87ff);
        wr(CDS_OFF_CUR_POS, 4'hf, 32'h8001_0402);
        vs_pulse();
        `CHK({o_cur_y_sign, o_cur_y_mag}, 12'h801, "y pos")
        `CHK({o_cur_x_sign, o_cur_x_mag}, 12'h402, "x pos")
    endtask : t_base_pos

    task automatic t_events;
        strobe(1'b1, 1'b0);
        rd_chk(CDS_OFF_STAT, 32'h0000_8000);
        wr(CDS_OFF_STAT, 4'hc, 32'hffff_0000);
        rd_chk(CDS_OFF_STAT, 32'h0703_8000);
        strobe(1'b1, 1'b0);
        `CHK(o_disp_evt, 1'b1, "display event")
        `CHK(o_vblank_evt, 1'b0, "no vblank event")
        wr(CDS_OFF_STAT, 4'h1, 32'h0000_0100);
        rd_chk(CDS_OFF_STAT, 32'h0703_8100);
        wr(CDS_OFF_STAT, 4'h2, 32'h0000_0100);
        rd_chk(CDS_OFF_STAT, 32'h0703_8000);
        `CHK(o_disp_evt, 1'b0, "display event cleared")
        @(posedge i_clk);
        i_vblank <= 1'b1;
        strobe(1'b0, 1'b1);
        rd_chk(CDS_OFF_STAT, 32'h0703_8003);
        `CHK(o_vblank_evt, 1'b1, "vblank event")
        @(posedge i_clk);
        i_vblank <= 1'b0;
        strobe(1'b0, 1'b1);
        rd_chk(CDS_OFF_STAT, 32'h0703_8002);
        wr(CDS_OFF_STAT, 4'h1, 32'h0000_0003);
        vs_pulse();
        rd_chk(CDS_OFF_STAT, 32'h0703_8200);
        wr(CDS_OFF_STAT, 4'h6, 32'h0000_0200);
        @(posedge i_clk);
        i_vblank <= 1'b1;
        strobe(1'b0, 1'b1);
        @(posedge i_clk);
        i_vblank <= 1'b0;
        rd_chk(CDS_OFF_STAT, 32'h0700_8000);
    endtask : t_events

    task automatic t_hotplug;
        @(posedge i_clk);
        i_hp_pin_n <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd_chk(CDS_OFF_STAT, 32'h0700_0400);
        `CHK(o_disp_evt, 1'b1, "hot-plug event")
        wr(CDS_OFF_STAT, 4'h2, 32'h0000_0400);
        rd_chk(CDS_OFF_STAT, 32'h0700_0000);
        @(posedge i_clk);
        i_hp_pin_n  <= 1'b1;
        i_hp_refclk <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_hp_pin_n <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd_chk(CDS_OFF_STAT, 32'h0700_8000);
        @(posedge i_clk);
        i_hp_pin_n <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_hp_refclk <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd_chk(CDS_OFF_STAT, 32'h0700_8000);
    endtask : t_hotplug

    task automatic t_palette;
        for (int c = 0; c < 4; c++) begin
            @(posedge i_clk);
            i_cur_pix <= 2'(c);
            @(posedge i_clk);
            #1;
            `CHK(o_cur_pal_idx, 3'(4 + c), "palette index")
        end
    endtask : t_palette

    // ****************************************
    // sequence, watchdog and verdict
    // ****************************************
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        miscompares = 0;
        n_checks    = 0;
        i_rst_n     = 1'b0;
        i_wr        = 1'b0;
        i_rd        = 1'b0;
        i_addr      = 20'h0;
        i_be        = 4'h0;
        i_wdata     = 32'h0;
        i_vsync     = 1'b0;
        i_vblank    = 1'b0;
        i_line_cmp  = 1'b0;
        i_ovl_upd   = 1'b0;
        i_hp_pin_n  = 1'b1;
        i_hp_refclk = 1'b0;
        i_cur_pix   = 2'h0;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_reset();
        t_dbuf();
        t_modes();
        t_base_pos();
        t_events();
        t_hotplug();
        t_palette();
        tally_and_finish();
    end

    initial begin
        #(4 * 20000);
        miscompares++;
        $display("FAIL %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule : test_cursor_and_display_status
